// *** rtl/icmb_mailbox.v ***
`timescale 1ns/10ps
`include "icmb_consts.vh"

// Functional notes
// R1 - All mailbox registers clear on reset
// R2 - Supervisor reads reply word0; processor writes
// R3 - Status code carries command acknowledge and status
// R4 - Hardware-set status blocks processor code writes
// R5 - Watchdog limit sets reply flag, code zero
// R6 - Watchdog lock holds until processor core reset
// R7 - Request irq enable gates request flag interrupt
// R8 - Only processor side sets reply flag
// R9 - Supervisor clears reply flag unless locked
// R10 - Processor sets reply flag after loading data
// R11 - Reply data: processor writes, supervisor reads
// R12 - Processor waits for flag clear before rewrite
// R13 - Request word0: supervisor writes, processor reads
// R14 - Master writes command code for slave
// R15 - Reply irq enable gates reply flag interrupt
// R16 - Only supervisor sets request flag
// R17 - Only processor clears request flag
// R18 - Master sets request flag after loading
// R19 - Request data words: supervisor writes only
// R20 - Master rewrites data after flag clears
// R21 - Reserved bits 7:6 read zero
// R22 - Interrupt levels: flag and enable both set
// R23 - Writes without permission are ignored
module icmb_mailbox #(
	parameter [`ICMB_WDT_W-1:0] WDT_LIMIT = `ICMB_WDT_LIMIT
) (
	// Clock and reset
	input  wire                    mclk_i,
	input  wire                    rst_n_i,
	// Supervisory core register port
	input  wire [`ICMB_ADDR_W-1:0] sup_addr_i,
	input  wire                    sup_wr_i,
	input  wire                    sup_rd_i,
	input  wire [15:0]             sup_wdata_i,
	output reg  [15:0]             sup_rdata_o,
	output reg                     sup_rvalid_o,
	// Processing core register port
	input  wire [`ICMB_ADDR_W-1:0] proc_addr_i,
	input  wire                    proc_wr_i,
	input  wire                    proc_rd_i,
	input  wire [15:0]             proc_wdata_i,
	output reg  [15:0]             proc_rdata_o,
	output reg                     proc_rvalid_o,
	// Processing core control
	input  wire                    processing_core_enable_i,
	input  wire                    proc_wdt_kick_i,
	// Interrupts and status
	output reg                     sup_irq_o,
	output reg                     proc_irq_o,
	output reg                     wdt_lock_o
);

	// ============================================================
	// Reset release
	reg        rst_meta_n;
	reg        rst_sync_n;

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ============================================================
	// Mailbox storage
	reg [3:0]  reply_status_code;
	reg        request_irq_enable;
	reg        reply_valid_flag;
	reg [15:0] slave_reply_word1;
	reg [3:0]  request_command_code;
	reg        reply_irq_enable;
	reg        request_valid_flag;
	reg [15:0] host_request_word1;
	reg [15:0] host_request_word2;
	reg        hw_lock;

	// ============================================================
	// Address decode
	function is_idx;
		input [`ICMB_ADDR_W-1:0] addr;
		input [`ICMB_ADDR_W-1:0] idx;
		begin
			is_idx = (addr == idx);
		end
	endfunction

	wire sup_wr_reply_status  = sup_wr_i  && is_idx(sup_addr_i,  `ICMB_IDX_REPLY_STATUS);
	wire sup_wr_req_command   = sup_wr_i  && is_idx(sup_addr_i,  `ICMB_IDX_REQ_COMMAND);
	wire sup_wr_req_data_a    = sup_wr_i  && is_idx(sup_addr_i,  `ICMB_IDX_REQ_DATA_A);
	wire sup_wr_req_data_b    = sup_wr_i  && is_idx(sup_addr_i,  `ICMB_IDX_REQ_DATA_B);
	wire proc_wr_reply_status = proc_wr_i && is_idx(proc_addr_i, `ICMB_IDX_REPLY_STATUS);
	wire proc_wr_reply_data   = proc_wr_i && is_idx(proc_addr_i, `ICMB_IDX_REPLY_DATA);
	wire proc_wr_req_command  = proc_wr_i && is_idx(proc_addr_i, `ICMB_IDX_REQ_COMMAND);

	// ============================================================
	// Watchdog on the processing core
	wire wdt_timeout;

	icmb_watchdog #(
		.LIMIT     (WDT_LIMIT)
	) u_watchdog (
		.mclk_i    (mclk_i),
		.rst_n_i   (rst_sync_n),
		.enable_i  (processing_core_enable_i),
		.kick_i    (proc_wdt_kick_i),
		.timeout_o (wdt_timeout)
	);

	// ============================================================
	// Hardware lock on the reply status
	// Disabling the core is its reset; that and the mailbox reset are the ways out of the lock
	always @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			hw_lock <= 1'b0; // R1
		end else if (!processing_core_enable_i) begin
			hw_lock <= 1'b0; // R6
		end else if (wdt_timeout) begin
			hw_lock <= 1'b1; // R5
		end
	end

	// ============================================================
	// Reply status byte
	wire       reply_set_sw = proc_wr_reply_status && proc_wdata_i[`ICMB_BIT_VALID];
	wire       reply_clr_sw = sup_wr_reply_status && !sup_wdata_i[`ICMB_BIT_VALID];
	reg        next_reply_valid_flag;
	reg [3:0]  next_reply_status_code;

	always @* begin
		next_reply_valid_flag  = reply_valid_flag;
		next_reply_status_code = reply_status_code;
		// Clear first, so a set in the same cycle wins
		if (reply_clr_sw) begin
			next_reply_valid_flag = 1'b0; // R9
		end
		if (hw_lock || wdt_timeout) begin
			next_reply_valid_flag  = 1'b1;                   // R5
			next_reply_status_code = `ICMB_WDT_STATUS_CODE; // R4
		end else if (proc_wr_reply_status) begin
			next_reply_status_code = proc_wdata_i[`ICMB_CODE_MSB:`ICMB_CODE_LSB]; // R3
			if (reply_set_sw) begin
				next_reply_valid_flag = 1'b1; // R8
			end
		end
	end

	always @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reply_status_code  <= `ICMB_RST_CODE; // R1
			reply_valid_flag   <= 1'b0;
			request_irq_enable <= 1'b0;
		end else begin
			reply_status_code <= next_reply_status_code; // R2
			reply_valid_flag  <= next_reply_valid_flag;
			// Enable bit stays writable by the processor even when locked
			if (proc_wr_reply_status) begin
				request_irq_enable <= proc_wdata_i[`ICMB_BIT_IRQ_EN]; // R7
			end
		end
	end

	// ============================================================
	// Reply data word
	always @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			slave_reply_word1 <= `ICMB_RST_WORD; // R1
		end else if (proc_wr_reply_data) begin
			slave_reply_word1 <= proc_wdata_i; // R11
		end
	end

	// ============================================================
	// Request command byte
	wire req_set = sup_wr_req_command && sup_wdata_i[`ICMB_BIT_VALID];
	wire req_clr = proc_wr_req_command && !proc_wdata_i[`ICMB_BIT_VALID];

	always @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			request_command_code <= `ICMB_RST_CODE; // R1
			reply_irq_enable     <= 1'b0;
			request_valid_flag   <= 1'b0;
		end else begin
			if (sup_wr_req_command) begin
				request_command_code <= sup_wdata_i[`ICMB_CODE_MSB:`ICMB_CODE_LSB]; // R13
				reply_irq_enable     <= sup_wdata_i[`ICMB_BIT_IRQ_EN];              // R15
			end
			// Set wins over a clear in the same cycle
			if (req_set) begin
				request_valid_flag <= 1'b1; // R16
			end else if (req_clr) begin
				request_valid_flag <= 1'b0; // R17
			end
		end
	end

	// ============================================================
	// Request data words
	always @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			host_request_word1 <= `ICMB_RST_WORD; // R1
			host_request_word2 <= `ICMB_RST_WORD;
		end else begin
			if (sup_wr_req_data_a) begin
				host_request_word1 <= sup_wdata_i; // R19
			end
			if (sup_wr_req_data_b) begin
				host_request_word2 <= sup_wdata_i; // R19
			end
		end
	end

	// ============================================================
	// Read mux, shared by both ports
	// Reserved bits and unmapped indices read as zero
	function [15:0] read_word;
		input [`ICMB_ADDR_W-1:0] addr;
		input [3:0]              rs_code;
		input                    rs_ien;
		input                    rs_valid;
		input [15:0]             rs_data;
		input [3:0]              rq_code;
		input                    rq_ien;
		input                    rq_valid;
		input [15:0]             rq_a;
		input [15:0]             rq_b;
		begin
			if (addr == `ICMB_IDX_REPLY_STATUS) begin
				read_word = {8'h00, 2'h0, rs_valid, rs_ien, rs_code}; // R21
			end else if (addr == `ICMB_IDX_REPLY_DATA) begin
				read_word = rs_data;
			end else if (addr == `ICMB_IDX_REQ_COMMAND) begin
				read_word = {8'h00, 2'h0, rq_valid, rq_ien, rq_code}; // R21
			end else if (addr == `ICMB_IDX_REQ_DATA_A) begin
				read_word = rq_a;
			end else if (addr == `ICMB_IDX_REQ_DATA_B) begin
				read_word = rq_b;
			end else begin
				read_word = 16'h0000;
			end
		end
	endfunction

	wire [15:0] sup_view  = read_word(sup_addr_i, reply_status_code, request_irq_enable,
		reply_valid_flag, slave_reply_word1, request_command_code, reply_irq_enable,
		request_valid_flag, host_request_word1, host_request_word2);
	wire [15:0] proc_view = read_word(proc_addr_i, reply_status_code, request_irq_enable,
		reply_valid_flag, slave_reply_word1, request_command_code, reply_irq_enable,
		request_valid_flag, host_request_word1, host_request_word2);

	always @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sup_rdata_o   <= `ICMB_RST_WORD;
			sup_rvalid_o  <= 1'b0;
			proc_rdata_o  <= `ICMB_RST_WORD;
			proc_rvalid_o <= 1'b0;
		end else begin
			sup_rvalid_o  <= sup_rd_i;
			proc_rvalid_o <= proc_rd_i;
			if (sup_rd_i) begin
				sup_rdata_o <= sup_view; // R2
			end
			if (proc_rd_i) begin
				proc_rdata_o <= proc_view; // R13
			end
		end
	end

	// ============================================================
	// Interrupt levels and lock status
	// Taken from the stored flags, so they lag the flag by one cycle
	always @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sup_irq_o  <= 1'b0;
			proc_irq_o <= 1'b0;
			wdt_lock_o <= 1'b0;
		end else begin
			sup_irq_o  <= reply_valid_flag && reply_irq_enable;     // R22
			proc_irq_o <= request_valid_flag && request_irq_enable; // R22
			wdt_lock_o <= hw_lock;
		end
	end

	// Writes by a core to a register it may not write have no decode
	// term above and so change nothing // R23

endmodule

// *** rtl/icmb_consts.vh ***
`ifndef ICMB_CONSTS_VH
`define ICMB_CONSTS_VH

// ============================================================
// Register indices
`define ICMB_ADDR_W              5
`define ICMB_IDX_REPLY_STATUS    5'h06
`define ICMB_IDX_REPLY_DATA      5'h07
`define ICMB_IDX_REQ_COMMAND     5'h0E
`define ICMB_IDX_REQ_DATA_A      5'h0F
`define ICMB_IDX_REQ_DATA_B      5'h10

// ============================================================
// Field positions, status/command byte
`define ICMB_CODE_MSB            3
`define ICMB_CODE_LSB            0
`define ICMB_BIT_IRQ_EN          4
`define ICMB_BIT_VALID           5
`define ICMB_RSVD_MSB            7
`define ICMB_RSVD_LSB            6

// ============================================================
// Reset values
`define ICMB_RST_BYTE            8'h00
`define ICMB_RST_WORD            16'h0000
`define ICMB_RST_CODE            4'h0

// ============================================================
// Watchdog
`define ICMB_WDT_W               16
`define ICMB_WDT_LIMIT           16'hFFFF
`define ICMB_WDT_STATUS_CODE     4'h0

`endif

// *** rtl/icmb_watchdog.v ***
`timescale 1ns/10ps
`include "icmb_consts.vh"

module icmb_watchdog #(
	parameter [`ICMB_WDT_W-1:0] LIMIT = `ICMB_WDT_LIMIT
) (
	// Clock and reset
	input  wire mclk_i,
	input  wire rst_n_i,
	// Control
	input  wire enable_i,
	input  wire kick_i,
	// Status
	output reg  timeout_o
);

	reg [`ICMB_WDT_W-1:0] count;

	// ============================================================
	// Counter, held clear while the core is disabled
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count     <= `ICMB_RST_WORD;
			timeout_o <= 1'b0;
		end else if (!enable_i) begin
			count     <= `ICMB_RST_WORD;
			timeout_o <= 1'b0;
		end else if (kick_i) begin
			count     <= `ICMB_RST_WORD;
			timeout_o <= 1'b0;
		end else if (count == LIMIT) begin
			// Saturate so the timeout stays a level
			timeout_o <= 1'b1;
		end else begin
			count <= count + {{(`ICMB_WDT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule

// *** test/icmb_mailbox_monitor.sv ***
`timescale 1ns/10ps
// ============================================================
// Port checker
module icmb_mailbox_monitor (
	input wire        mclk_i,
	input wire        rst_n_i,
	input wire [4:0]  sup_addr_i,
	input wire        sup_wr_i,
	input wire        sup_rd_i,
	input wire [15:0] sup_rdata_o,
	input wire        sup_rvalid_o,
	input wire [4:0]  proc_addr_i,
	input wire        proc_wr_i,
	input wire        proc_rd_i,
	input wire [15:0] proc_rdata_o,
	input wire        proc_rvalid_o,
	input wire        processing_core_enable_i,
	input wire        sup_irq_o,
	input wire        proc_irq_o,
	input wire        wdt_lock_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	wire s_byte = sup_addr_i == 5'h06 || sup_addr_i == 5'h0E;
	wire p_byte = proc_addr_i == 5'h06 || proc_addr_i == 5'h0E;
	chk_sup_rd_answer: assert property (sup_rd_i |=> sup_rvalid_o)
		else $error("supervisor read not answered");
	chk_proc_rd_answer: assert property (proc_rd_i |=> proc_rvalid_o)
		else $error("processor read not answered");
	chk_sup_rsvd_zero: assert property (sup_rd_i && s_byte |=> sup_rdata_o[15:6] == 10'h000)
		else $error("supervisor reserved bits set");
	chk_proc_rsvd_zero: assert property (proc_rd_i && p_byte |=> proc_rdata_o[15:6] == 10'h000)
		else $error("processor reserved bits set");
	chk_lock_status: assert property (sup_rd_i && sup_addr_i == 5'h06 && wdt_lock_o
		|=> sup_rdata_o[5] && sup_rdata_o[3:0] == 4'h0)
		else $error("locked status not flag with code zero");
	chk_lock_holds: assert property (wdt_lock_o && processing_core_enable_i |=> wdt_lock_o)
		else $error("lock dropped while core enabled");
	chk_lock_release: assert property ($fell(processing_core_enable_i) |-> ##[1:3] !wdt_lock_o)
		else $error("lock kept through core reset");
	chk_proc_irq_cause: assert property ($rose(proc_irq_o) |-> $past(sup_wr_i, 2) || $past(proc_wr_i, 2))
		else $error("processor irq rose without write");
	chk_sup_irq_cause: assert property ($rose(sup_irq_o)
		|-> $past(sup_wr_i, 2) || $past(proc_wr_i, 2) || wdt_lock_o)
		else $error("supervisor irq rose without cause");
	chk_sup_irq_keep: assert property (sup_irq_o && !sup_wr_i && !$past(sup_wr_i) |=> sup_irq_o)
		else $error("supervisor irq dropped without supervisor write");
	chk_proc_irq_keep: assert property (proc_irq_o && !proc_wr_i && !$past(proc_wr_i) |=> proc_irq_o)
		else $error("processor irq dropped without processor write");
	cover property ($rose(wdt_lock_o));
	cover property ($rose(sup_irq_o));
	cover property ($rose(proc_irq_o));
endmodule

bind icmb_mailbox icmb_mailbox_monitor u_mon (.mclk_i, .rst_n_i, .sup_addr_i, .sup_wr_i, .sup_rd_i,
	.sup_rdata_o, .sup_rvalid_o, .proc_addr_i, .proc_wr_i, .proc_rd_i, .proc_rdata_o,
	.proc_rvalid_o, .processing_core_enable_i, .sup_irq_o, .proc_irq_o, .wdt_lock_o);

// *** test/icmb_proc_model.sv ***
`timescale 1ns/10ps
// ============================================================
// Processing-core software on the slave register port
module icmb_proc_model (
	input  wire         mclk_i,
	input  wire         kick_en_i,
	output logic [4:0]  addr_o,
	output logic        wr_o,
	output logic        rd_o,
	output logic [15:0] wdata_o,
	output logic        kick_o,
	input  wire  [15:0] rdata_i,
	input  wire         rvalid_i
);
	logic [2:0] cnt;
	initial {addr_o, wr_o, rd_o, wdata_o, kick_o, cnt} = '0;
	// Kick every 5 cycles, well inside the shortened limit
	always @(negedge mclk_i) begin
		cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
		kick_o <= kick_en_i && cnt == 3'h0;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(negedge mclk_i);
		{addr_o, wdata_o, wr_o} = {a, v, 1'b1};
		@(negedge mclk_i);
		wr_o = 0;
	endtask
	// No answer shows as unknown data
	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		@(negedge mclk_i);
		{addr_o, rd_o} = {a, 1'b1};
		@(negedge mclk_i);
		rd_o = 0;
		v = rvalid_i ? rdata_i : 16'hXXXX;
	endtask
endmodule

// *** test/intercore_mailbox_test.sv ***
`timescale 1ns/10ps
// ============================================================
// Mailbox bench with reference model
module intercore_mailbox_test;
	logic        mclk_i = 0;
	logic        rst_n_i = 0;
	logic [4:0]  sup_addr_i = 0;
	logic        sup_wr_i = 0;
	logic        sup_rd_i = 0;
	logic [15:0] sup_wdata_i = 0;
	logic        core_en = 1;
	logic        kick_en = 1;
	wire  [15:0] sup_rdata_o, proc_rdata_o, proc_wdata_i;
	wire  [4:0]  proc_addr_i;
	wire         sup_rvalid_o, proc_rvalid_o, proc_wr_i, proc_rd_i, kick;
	wire         sup_irq_o, proc_irq_o, wdt_lock_o;
	logic [3:0]  rsc, rqc;
	logic [15:0] rsd, rqa, rqb, d;
	logic [4:0]  a;
	logic        rse, rsv, rqe, rqv, lk;
	int          n_errors = 0, tests_run = 0, i;
	logic [4:0]  amap [6] = '{5'h06, 5'h07, 5'h0E, 5'h0F, 5'h10, 5'h15};
	always #5 mclk_i = ~mclk_i;
	icmb_mailbox #(.WDT_LIMIT(16'h0010)) dut (.mclk_i, .rst_n_i, .sup_addr_i, .sup_wr_i,
		.sup_rd_i, .sup_wdata_i, .sup_rdata_o, .sup_rvalid_o, .proc_addr_i, .proc_wr_i,
		.proc_rd_i, .proc_wdata_i, .proc_rdata_o, .proc_rvalid_o, .processing_core_enable_i(core_en),
		.proc_wdt_kick_i(kick), .sup_irq_o, .proc_irq_o, .wdt_lock_o);
	icmb_proc_model pm (.mclk_i, .kick_en_i(kick_en), .addr_o(proc_addr_i), .wr_o(proc_wr_i),
		.rd_o(proc_rd_i), .wdata_o(proc_wdata_i), .kick_o(kick), .rdata_i(proc_rdata_o),
		.rvalid_i(proc_rvalid_o));
	task automatic test_done;
		if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [15:0] expv(input logic [4:0] x);
		case (x)
			5'h06: expv = {10'h000, rsv, rse, rsc};
			5'h07: expv = rsd;
			5'h0E: expv = {10'h000, rqv, rqe, rqc};
			5'h0F: expv = rqa;
			5'h10: expv = rqb;
			default: expv = 16'h0000;
		endcase
	endfunction
	task automatic s_wr(input logic [4:0] x, input logic [15:0] v);
		if (x == 5'h06 && !v[5] && !lk) rsv = 0;
		if (x == 5'h0E) {rqv, rqe, rqc} = {rqv | v[5], v[4:0]};
		if (x == 5'h0F) rqa = v;
		if (x == 5'h10) rqb = v;
		@(negedge mclk_i);
		{sup_addr_i, sup_wdata_i, sup_wr_i} = {x, v, 1'b1};
		@(negedge mclk_i);
		sup_wr_i = 0;
	endtask
	task automatic p_wr(input logic [4:0] x, input logic [15:0] v);
		if (x == 5'h06) rse = v[4];
		if (x == 5'h06 && !lk) {rsv, rsc} = {rsv | v[5], v[3:0]};
		if (x == 5'h07) rsd = v;
		if (x == 5'h0E && !v[5]) rqv = 0;
		pm.wr(x, v);
	endtask
	task automatic chk_all;
		foreach (amap[j]) begin
			@(negedge mclk_i);
			{sup_addr_i, sup_rd_i} = {amap[j], 1'b1};
			@(negedge mclk_i);
			sup_rd_i = 0;
			chk("sup_rdata", sup_rvalid_o ? expv(amap[j]) : 16'hFFFF, sup_rdata_o);
			pm.rd(amap[j], d);
			chk("proc_rdata", expv(amap[j]), d);
		end
		chk("sup_irq", {15'h0, rsv & rqe}, {15'h0, sup_irq_o});
		chk("proc_irq", {15'h0, rqv & rse}, {15'h0, proc_irq_o});
		chk("wdt_lock", {15'h0, lk}, {15'h0, wdt_lock_o});
	endtask
	initial begin
		{rsc, rqc, rsd, rqa, rqb, rse, rsv, rqe, rqv, lk} = '0;
		d = $urandom(32'hF5EE77AA);
		repeat (3) @(negedge mclk_i);
		rst_n_i = 1;
		repeat (3) @(negedge mclk_i);
		chk_all;
		for (i = 0; i < 80; i++) begin
			a = amap[$urandom % 6];
			d = $urandom;
			if ($urandom % 2) begin
				if (rqv && a > 5'h0E) a = 5'h0E;
				s_wr(a, d);
			end else begin
				if (rsv && a == 5'h07) a = 5'h06;
				p_wr(a, d);
			end
			if (i % 10 == 9) chk_all;
		end
		s_wr(5'h06, 16'h0000);
		s_wr(5'h0E, 16'h0010);
		kick_en = 0;
		for (i = 0; i < 200 && !wdt_lock_o; i++) @(negedge mclk_i);
		if (!wdt_lock_o) begin
			n_errors++;
			test_done;
		end
		{lk, rsv, rsc} = 6'h30;
		chk_all;
		p_wr(5'h06, 16'h003A);
		s_wr(5'h06, 16'h0000);
		chk_all;
		core_en = 0;
		repeat (4) @(negedge mclk_i);
		lk = 0;
		core_en = 1;
		kick_en = 1;
		s_wr(5'h06, 16'h0000);
		chk_all;
		test_done;
	end
endmodule
